// [rtl/audio_pin_pkg.sv]
package audio_pin_pkg;

	// Register byte addresses on the bus
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_PORT_SEL  = 8'h04;
	localparam logic [7:0] ADDR_GPIO_MODE = 8'h08;
	localparam logic [7:0] ADDR_GPIO_OUT  = 8'h0c;
	localparam logic [7:0] ADDR_GPIO_IN   = 8'h10;
	localparam logic [7:0] ADDR_STATUS    = 8'h14;
	localparam logic [7:0] ADDR_TX_DATA   = 8'h18;
	localparam logic [7:0] ADDR_RX_DATA   = 8'h1c;

	// Control register fields
	localparam int CTRL_SHARED = 0;
	localparam int CTRL_NET    = 1;
	localparam int CTRL_RCKDIR = 2;
	localparam int CTRL_TCKDIR = 3;
	localparam int CTRL_OF0    = 4;
	localparam int CTRL_DTX    = 5;
	localparam int CTRL_TXEN   = 6;
	localparam int CTRL_RXEN   = 7;
	localparam int CTRL_W      = 8;

	// Status register fields
	localparam int STAT_IF0    = 0;
	localparam int STAT_RXFULL = 1;
	localparam int STAT_RXSRC  = 2;

	// Pin indexes in port select, mode and data fields
	localparam int PIN_RCK = 0;
	localparam int PIN_TCK = 1;
	localparam int PIN_DAT = 2;
	localparam int NPINS   = 3;

	// Values after reset: every pin a disconnected port line
	localparam logic [CTRL_W-1:0]  CTRL_RST      = 8'h00;
	localparam logic [NPINS-1:0]   PORT_SEL_RST  = 3'h0;
	localparam logic [2*NPINS-1:0] GPIO_MODE_RST = 6'h00;
	localparam logic [NPINS-1:0]   GPIO_OUT_RST  = 3'h0;

	// Port line modes, two bits per pin
	typedef enum logic [1:0] {
		GPIO_OFF = 2'h0,
		GPIO_IN  = 2'h1,
		GPIO_OUT = 2'h2
	} gpio_mode_t;

	// Default serial word length and bit clock divider (half period in hclk cycles)
	localparam int WORD_BITS = 24;
	localparam int CLK_DIV   = 4;

endpackage

// [rtl/link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface link_if #(parameter int WORD_BITS = 24);
	// Bus-clock side to link side
	logic [WORD_BITS-1:0] tx_word;
	logic                 tx_tgl;
	logic [7:0]           cfg;
	// Link side to bus-clock side
	logic [WORD_BITS-1:0] rx_word;
	logic                 rx_tgl;
	logic                 if0;
	logic                 of0;

	modport core (output tx_word, output tx_tgl, output cfg,
		input rx_word, input rx_tgl, input if0, input of0);
	modport link (input tx_word, input tx_tgl, input cfg,
		output rx_word, output rx_tgl, output if0, output of0);
endinterface
`default_nettype wire

// [rtl/audio_link.sv]
`timescale 1ns/1ps
`default_nettype none
module audio_link #(
	parameter int WORD_BITS = 24
) (
	input  wire logic link_clk,
	input  wire logic link_rst_n,
	link_if.link      lk,
	input  wire logic frame_sync,
	input  wire logic sdat_i,
	input  wire logic rck_pin_i,
	output logic      sdat_o_q
);
	localparam int CW = $clog2(WORD_BITS);
	localparam logic [CW-1:0] LAST = CW'(WORD_BITS - 1);

	if (WORD_BITS < 2 || WORD_BITS > 32) begin : g_chk
		$error("audio_link: WORD_BITS must be 2 to 32");
	end

	logic [9:0]           s1_q;
	logic [9:0]           s2_q;
	logic                 tx_seen_q;
	logic [WORD_BITS-1:0] tx_hold_q;
	logic [WORD_BITS-1:0] tx_sh_q;
	logic [WORD_BITS-1:0] rx_sh_q;
	logic [WORD_BITS-1:0] rx_word_q;
	logic                 rx_tgl_q;
	logic                 if0_q;
	logic                 of0_q;
	logic [CW-1:0]        bit_cnt_q;
	logic                 slot_start;
	logic                 flag_evt;
	logic [7:0]           cfg;

	// Config levels, toggle and flag pin pass two flops into this domain
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			s1_q <= 10'h000;
			s2_q <= 10'h000;
		end else begin
			s1_q <= {rck_pin_i, lk.tx_tgl, lk.cfg};
			s2_q <= s1_q;
		end
	end
	assign cfg = s2_q[7:0];

	// Slot boundaries come from the frame sync or the word counter
	assign slot_start = frame_sync || (bit_cnt_q == LAST);
	assign flag_evt   = cfg[audio_pin_pkg::CTRL_NET] ? slot_start : frame_sync;

	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			bit_cnt_q <= '0;
		end else if (slot_start) begin
			bit_cnt_q <= '0;
		end else begin
			bit_cnt_q <= bit_cnt_q + 1'b1;
		end
	end

	// Transmit word taken over on each toggle from the bus side
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			tx_seen_q <= 1'b0;
			tx_hold_q <= '0;
		end else if (s2_q[8] != tx_seen_q) begin
			tx_seen_q <= s2_q[8];
			tx_hold_q <= lk.tx_word;
		end
	end

	// Transmit shifter five drives the data line, MSB first
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			tx_sh_q  <= '0;
			sdat_o_q <= 1'b0;
		end else if (!cfg[audio_pin_pkg::CTRL_TXEN]) begin
			tx_sh_q  <= '0;
			sdat_o_q <= 1'b0;
		end else if (slot_start) begin
			sdat_o_q <= tx_hold_q[WORD_BITS-1];
			tx_sh_q  <= {tx_hold_q[WORD_BITS-2:0], 1'b0};
		end else begin
			sdat_o_q <= tx_sh_q[WORD_BITS-1];
			tx_sh_q  <= {tx_sh_q[WORD_BITS-2:0], 1'b0};
		end
	end

	// Receive shifter zero collects the input line, word ends at the slot end
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			rx_sh_q   <= '0;
			rx_word_q <= '0;
			rx_tgl_q  <= 1'b0;
		end else if (cfg[audio_pin_pkg::CTRL_RXEN]) begin
			rx_sh_q <= {rx_sh_q[WORD_BITS-2:0], sdat_i};
			if (bit_cnt_q == LAST) begin
				rx_word_q <= {rx_sh_q[WORD_BITS-2:0], sdat_i};
				rx_tgl_q  <= ~rx_tgl_q;
			end
		end
	end

	// Serial flag zero: output latched, input captured on the flag event
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			of0_q <= 1'b0;
			if0_q <= 1'b0;
		end else if (flag_evt) begin
			of0_q <= cfg[audio_pin_pkg::CTRL_OF0];
			if (cfg[audio_pin_pkg::CTRL_SHARED] && !cfg[audio_pin_pkg::CTRL_RCKDIR]) begin
				if0_q <= s2_q[9];
			end
		end
	end

	assign lk.rx_word = rx_word_q;
	assign lk.rx_tgl  = rx_tgl_q;
	assign lk.if0     = if0_q;
	assign lk.of0     = of0_q;

	a_slot_count: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		bit_cnt_q <= LAST)
		else $error("bit counter passed word end");
	a_rx_word_out: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		(cfg[audio_pin_pkg::CTRL_RXEN] && bit_cnt_q == LAST)
		|=> (rx_tgl_q != $past(rx_tgl_q)) && (rx_word_q[0] == $past(sdat_i)))
		else $error("received word not handed over");
	a_of0_stable: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		!flag_evt |=> $stable(of0_q))
		else $error("output flag moved off event");
	a_tx_first_bit: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		(cfg[audio_pin_pkg::CTRL_TXEN] && slot_start && $stable(cfg))
		|=> sdat_o_q == $past(tx_hold_q[WORD_BITS-1]))
		else $error("slot did not start with word MSB");
endmodule
`default_nettype wire

// [rtl/audio_serial_pins.sv]
`timescale 1ns/1ps
`default_nettype none
module audio_serial_pins #(
	parameter int WORD_BITS = audio_pin_pkg::WORD_BITS,
	parameter int CLK_DIV   = audio_pin_pkg::CLK_DIV
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        link_clk,
	input  wire logic        frame_sync,
	input  wire logic        receive_bit_clock_pin_i,
	output logic             receive_bit_clock_pin_o,
	output logic             receive_bit_clock_pin_oe,
	input  wire logic        transmit_bit_clock_pin_i,
	output logic             transmit_bit_clock_pin_o,
	output logic             transmit_bit_clock_pin_oe,
	input  wire logic        serial_in_line_zero_i,
	output logic             serial_out_line_five_o,
	output logic             serial_out_line_five_oe
);
	localparam int NP = audio_pin_pkg::NPINS;
	localparam int DW = $clog2(CLK_DIV + 1);
	localparam logic [DW-1:0] DIV_LAST = DW'(CLK_DIV - 1);

	if (CLK_DIV < 1 || WORD_BITS < 2 || WORD_BITS > 32) begin : g_chk
		$error("audio_serial_pins: CLK_DIV or WORD_BITS out of range");
	end

	// Address hit on a mapped register word
	function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
		hit = (a[31:8] == 24'h000000) && (a[7:0] == off);
	endfunction

	// Port line mode of one pin
	function automatic audio_pin_pkg::gpio_mode_t pin_mode(input logic [2*NP-1:0] m,
		input int idx);
		pin_mode = audio_pin_pkg::gpio_mode_t'(m[2*idx +: 2]);
	endfunction

	link_if #(.WORD_BITS(WORD_BITS)) lk ();

	logic                              hreadyout_q;
	logic                              hresp_q;
	logic [31:0]                       hrdata_q;
	logic                              wr_pend_q;
	logic [7:0]                        wr_addr_q;
	logic [audio_pin_pkg::CTRL_W-1:0]  ctrl_q;
	logic [NP-1:0]                     port_sel_q;
	logic [2*NP-1:0]                   gpio_mode_q;
	logic [NP-1:0]                     gpio_out_q;
	logic [WORD_BITS-1:0]              tx_data_q;
	logic                              tx_tgl_q;
	logic [WORD_BITS-1:0]              rx_data_q;
	logic                              rx_full_q;
	logic                              rx_seen_q;
	logic [NP+2:0]                     sy1_q;
	logic [NP+2:0]                     sy2_q;
	logic [DW-1:0]                     div_cnt_q;
	logic                              bclk_q;
	logic [NP-1:0]                     pin_o_q;
	logic [NP-1:0]                     pin_oe_q;
	logic [31:0]                       rd_d;
	logic                              addr_ok;
	logic                              rd_rx;
	logic                              sdat_link;
	logic                              shared;
	logic [NP-1:0]                     gpio_in;

	assign addr_ok = hsel && htrans[1] && hready;
	assign rd_rx   = addr_ok && !hwrite && hit(haddr, audio_pin_pkg::ADDR_RX_DATA);
	assign shared  = ctrl_q[audio_pin_pkg::CTRL_SHARED];

	// Bus answer: zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_q <= 1'b0;
			hresp_q     <= 1'b0;
		end else begin
			hreadyout_q <= 1'b1;
			hresp_q     <= 1'b0;
		end
	end

	// Write address is held over to the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= addr_ok && hwrite && (haddr[31:8] == 24'h000000);
			wr_addr_q <= haddr[7:0];
		end
	end

	// Writable registers; unmapped writes fall through
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q      <= audio_pin_pkg::CTRL_RST;
			port_sel_q  <= audio_pin_pkg::PORT_SEL_RST;
			gpio_mode_q <= audio_pin_pkg::GPIO_MODE_RST;
			gpio_out_q  <= audio_pin_pkg::GPIO_OUT_RST;
			tx_data_q   <= '0;
			tx_tgl_q    <= 1'b0;
		end else if (wr_pend_q) begin
			case (wr_addr_q)
				audio_pin_pkg::ADDR_CTRL: begin
					ctrl_q <= hwdata[audio_pin_pkg::CTRL_W-1:0];
				end
				audio_pin_pkg::ADDR_PORT_SEL: begin
					port_sel_q <= hwdata[NP-1:0];
				end
				audio_pin_pkg::ADDR_GPIO_MODE: begin
					gpio_mode_q <= hwdata[2*NP-1:0];
				end
				audio_pin_pkg::ADDR_GPIO_OUT: begin
					gpio_out_q <= hwdata[NP-1:0];
				end
				audio_pin_pkg::ADDR_TX_DATA: begin
					tx_data_q <= hwdata[WORD_BITS-1:0];
					tx_tgl_q  <= ~tx_tgl_q;
				end
				default: begin
					ctrl_q <= ctrl_q;
				end
			endcase
		end
	end

	// Link flags, receive toggle and pin levels pass two flops into the bus clock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sy1_q <= '0;
			sy2_q <= '0;
		end else begin
			sy1_q <= {lk.of0, lk.if0, lk.rx_tgl, serial_in_line_zero_i,
				transmit_bit_clock_pin_i, receive_bit_clock_pin_i};
			sy2_q <= sy1_q;
		end
	end

	// Port inputs read only on pins in input mode, else zero
	for (genvar i = 0; i < NP; i++) begin : g_in
		assign gpio_in[i] = !port_sel_q[i] && (pin_mode(gpio_mode_q, i) == audio_pin_pkg::GPIO_IN)
			&& sy2_q[i];
	end

	// Received word; full flag set wins over clear by read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_seen_q <= 1'b0;
			rx_data_q <= '0;
			rx_full_q <= 1'b0;
		end else begin
			if (sy2_q[NP] != rx_seen_q) begin
				rx_seen_q <= sy2_q[NP];
				rx_data_q <= lk.rx_word;
				rx_full_q <= 1'b1;
			end else if (rd_rx) begin
				rx_full_q <= 1'b0;
			end
		end
	end

	// Read data mux
	always_comb begin
		rd_d = 32'h00000000;
		if (hit(haddr, audio_pin_pkg::ADDR_CTRL)) begin
			rd_d[audio_pin_pkg::CTRL_W-1:0] = ctrl_q;
		end else if (hit(haddr, audio_pin_pkg::ADDR_PORT_SEL)) begin
			rd_d[NP-1:0] = port_sel_q;
		end else if (hit(haddr, audio_pin_pkg::ADDR_GPIO_MODE)) begin
			rd_d[2*NP-1:0] = gpio_mode_q;
		end else if (hit(haddr, audio_pin_pkg::ADDR_GPIO_OUT)) begin
			rd_d[NP-1:0] = gpio_out_q;
		end else if (hit(haddr, audio_pin_pkg::ADDR_GPIO_IN)) begin
			rd_d[NP-1:0] = gpio_in;
		end else if (hit(haddr, audio_pin_pkg::ADDR_STATUS)) begin
			rd_d[audio_pin_pkg::STAT_IF0]    = sy2_q[NP+1];
			rd_d[audio_pin_pkg::STAT_RXFULL] = rx_full_q;
			rd_d[audio_pin_pkg::STAT_RXSRC]  = shared;
		end else if (hit(haddr, audio_pin_pkg::ADDR_TX_DATA)) begin
			rd_d[WORD_BITS-1:0] = tx_data_q;
		end else if (hit(haddr, audio_pin_pkg::ADDR_RX_DATA)) begin
			rd_d[WORD_BITS-1:0] = rx_data_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h00000000;
		end else if (addr_ok && !hwrite) begin
			hrdata_q <= rd_d;
		end
	end

	// Bit clock made here when a clock pin drives out
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt_q <= '0;
			bclk_q    <= 1'b0;
		end else if (div_cnt_q == DIV_LAST) begin
			div_cnt_q <= '0;
			bclk_q    <= ~bclk_q;
		end else begin
			div_cnt_q <= div_cnt_q + 1'b1;
		end
	end

	// Pin drivers: serial role when selected, port role otherwise
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_o_q  <= '0;
			pin_oe_q <= '0;
		end else begin
			for (int i = 0; i < NP; i++) begin
				if (port_sel_q[i]) begin
					pin_o_q[i]  <= 1'b0;
					pin_oe_q[i] <= 1'b0;
				end else if (pin_mode(gpio_mode_q, i) == audio_pin_pkg::GPIO_OUT) begin
					pin_o_q[i]  <= gpio_out_q[i];
					pin_oe_q[i] <= 1'b1;
				end else begin
					pin_o_q[i]  <= 1'b0;
					pin_oe_q[i] <= 1'b0;
				end
			end
			if (port_sel_q[audio_pin_pkg::PIN_RCK]) begin
				// Receive pin: clock in separate timing, flag zero in shared
				pin_oe_q[audio_pin_pkg::PIN_RCK] <= ctrl_q[audio_pin_pkg::CTRL_RCKDIR];
				pin_o_q[audio_pin_pkg::PIN_RCK]  <= shared ? sy2_q[NP+2] : bclk_q;
			end
			if (port_sel_q[audio_pin_pkg::PIN_TCK]) begin
				pin_oe_q[audio_pin_pkg::PIN_TCK] <= ctrl_q[audio_pin_pkg::CTRL_TCKDIR];
				pin_o_q[audio_pin_pkg::PIN_TCK]  <= bclk_q;
			end
			if (port_sel_q[audio_pin_pkg::PIN_DAT]) begin
				pin_oe_q[audio_pin_pkg::PIN_DAT] <= ctrl_q[audio_pin_pkg::CTRL_DTX];
			end
		end
	end

	// Link side configuration; shifters only run when the data pin is serial
	always_comb begin
		lk.cfg = ctrl_q;
		lk.cfg[audio_pin_pkg::CTRL_TXEN] = ctrl_q[audio_pin_pkg::CTRL_TXEN]
			&& ctrl_q[audio_pin_pkg::CTRL_DTX] && port_sel_q[audio_pin_pkg::PIN_DAT];
		lk.cfg[audio_pin_pkg::CTRL_RXEN] = ctrl_q[audio_pin_pkg::CTRL_RXEN]
			&& !ctrl_q[audio_pin_pkg::CTRL_DTX] && port_sel_q[audio_pin_pkg::PIN_DAT];
		lk.cfg[audio_pin_pkg::CTRL_SHARED] = shared && port_sel_q[audio_pin_pkg::PIN_RCK];
	end
	assign lk.tx_word = tx_data_q;
	assign lk.tx_tgl  = tx_tgl_q;

	audio_link #(.WORD_BITS(WORD_BITS)) u_link (
		.link_clk   (link_clk),
		.link_rst_n (hresetn),
		.lk         (lk.link),
		.frame_sync (frame_sync),
		.sdat_i     (serial_in_line_zero_i),
		.rck_pin_i  (receive_bit_clock_pin_i),
		.sdat_o_q   (sdat_link)
	);

	assign hreadyout                 = hreadyout_q;
	assign hresp                     = hresp_q;
	assign hrdata                    = hrdata_q;
	assign receive_bit_clock_pin_o   = pin_o_q[audio_pin_pkg::PIN_RCK];
	assign receive_bit_clock_pin_oe  = pin_oe_q[audio_pin_pkg::PIN_RCK];
	assign transmit_bit_clock_pin_o  = pin_o_q[audio_pin_pkg::PIN_TCK];
	assign transmit_bit_clock_pin_oe = pin_oe_q[audio_pin_pkg::PIN_TCK];
	assign serial_out_line_five_oe   = pin_oe_q[audio_pin_pkg::PIN_DAT];
	// Data line level: link shifter flop in serial role, port flop otherwise
	assign serial_out_line_five_o    = port_sel_q[audio_pin_pkg::PIN_DAT] ? sdat_link
		: pin_o_q[audio_pin_pkg::PIN_DAT];

	a_flag_dir: assert property (@(posedge hclk) disable iff (!hresetn)
		(port_sel_q[audio_pin_pkg::PIN_RCK] && shared)
		|=> receive_bit_clock_pin_oe == $past(ctrl_q[audio_pin_pkg::CTRL_RCKDIR]))
		else $error("flag pin direction wrong");
	a_rck_clock: assert property (@(posedge hclk) disable iff (!hresetn)
		(port_sel_q[audio_pin_pkg::PIN_RCK] && !shared)
		|=> receive_bit_clock_pin_o == $past(bclk_q))
		else $error("receive pin not carrying clock");
	a_flag_value: assert property (@(posedge hclk) disable iff (!hresetn)
		(port_sel_q[audio_pin_pkg::PIN_RCK] && shared)
		|=> receive_bit_clock_pin_o == $past(sy2_q[NP+2]))
		else $error("flag pin not showing output flag");
	a_tck_dir: assert property (@(posedge hclk) disable iff (!hresetn)
		port_sel_q[audio_pin_pkg::PIN_TCK]
		|=> transmit_bit_clock_pin_oe == $past(ctrl_q[audio_pin_pkg::CTRL_TCKDIR]))
		else $error("transmit clock direction wrong");
	a_gpio_drive: assert property (@(posedge hclk) disable iff (!hresetn)
		(!port_sel_q[0] && gpio_mode_q[1:0] == 2'h2)
		|=> receive_bit_clock_pin_oe && receive_bit_clock_pin_o == $past(gpio_out_q[0]))
		else $error("port line not driving");
	a_gpio_off: assert property (@(posedge hclk) disable iff (!hresetn)
		(!port_sel_q[1] && gpio_mode_q[3:2] != 2'h2) |=> !transmit_bit_clock_pin_oe)
		else $error("disconnected pin drives");
	a_reset_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(hreadyout_q) |-> !receive_bit_clock_pin_oe && !transmit_bit_clock_pin_oe
		&& !serial_out_line_five_oe) else $error("pin driven after reset");
	a_rx_full: assert property (@(posedge hclk) disable iff (!hresetn)
		(sy2_q[NP] != rx_seen_q) |=> rx_full_q && !$stable(rx_seen_q))
		else $error("received word lost");

	// Transmit clock and data pin roles, ready flag clear on read
	a_tck_clock: assert property (@(posedge hclk) disable iff (!hresetn)
		port_sel_q[audio_pin_pkg::PIN_TCK]
		|=> transmit_bit_clock_pin_o == $past(bclk_q))
		else $error("transmit pin not carrying clock");
	a_data_dir: assert property (@(posedge hclk) disable iff (!hresetn)
		port_sel_q[audio_pin_pkg::PIN_DAT]
		|=> serial_out_line_five_oe == $past(ctrl_q[audio_pin_pkg::CTRL_DTX]))
		else $error("data pin direction wrong");
	a_data_port: assert property (@(posedge hclk) disable iff (!hresetn)
		(!port_sel_q[2] && gpio_mode_q[5:4] == 2'h2) |=> serial_out_line_five_oe
		&& (port_sel_q[2] || serial_out_line_five_o == $past(gpio_out_q[2])))
		else $error("data port line not driving");
	a_rx_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		(rd_rx && sy2_q[NP] == rx_seen_q) |=> !rx_full_q)
		else $error("ready flag not cleared by read");
endmodule
`default_nettype wire

// [bench/audio_peer.sv]
`timescale 1ns/1ps
`default_nettype none
module audio_peer #(
	parameter logic [23:0] WORD = 24'h3c5a96
) (
	input  wire logic        link_clk,
	output logic             frame_sync,
	output logic             sdat,
	input  wire logic        sdo,
	output logic [23:0]      got
);
	logic [4:0]  cnt_q = 5'h0;
	logic [23:0] cap_q = 24'h0;

	// Slot counter, frame sync marks the last bit cycle of each word
	always @(posedge link_clk) begin
		cnt_q <= (cnt_q == 5'h17) ? 5'h0 : cnt_q + 5'h1;
	end
	assign frame_sync = (cnt_q == 5'h0);
	// Word sent MSB first from the cycle after frame sync, LSB in the frame sync cycle
	assign sdat = (cnt_q == 5'h0) ? WORD[0] : WORD[5'h18 - cnt_q];
	// Device output captured one bit behind the slot start
	always @(posedge link_clk) begin
		cap_q <= {cap_q[22:0], sdo};
		if (cnt_q == 5'h0) begin
			got <= {cap_q[22:0], sdo};
		end
	end
endmodule
`default_nettype wire

// [bench/audio_serial_pins_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module audio_serial_pins_bench;
	logic        hclk = 1'b0;
	logic        link_clk = 1'b0;
	logic        hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd_q;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        fs, sdi, rck_o, rck_oe, tck_o, tck_oe, dat_o, dat_oe;
	logic        rck_drv, tck_drv;
	logic [23:0] got;
	int          n_fail = 0;
	int          total_checks = 0;

	always #50 hclk = ~hclk;
	always #7.5 link_clk = ~link_clk;

	audio_serial_pins DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.link_clk(link_clk), .frame_sync(fs),
		.receive_bit_clock_pin_i(rck_oe ? rck_o : rck_drv),
		.receive_bit_clock_pin_o(rck_o), .receive_bit_clock_pin_oe(rck_oe),
		.transmit_bit_clock_pin_i(tck_oe ? tck_o : tck_drv),
		.transmit_bit_clock_pin_o(tck_o), .transmit_bit_clock_pin_oe(tck_oe),
		.serial_in_line_zero_i(sdi), .serial_out_line_five_o(dat_o),
		.serial_out_line_five_oe(dat_oe));

	audio_peer peer (.link_clk(link_clk), .frame_sync(fs), .sdat(sdi), .sdo(dat_o),
		.got(got));

	// Compare and count
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// Single AHB transfer: address phase, then data phase
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd_q = hrdata;
		chk("hresp", 32'h0, hresp);
	endtask

	task rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, rd_q & m);
	endtask

	// Count level changes of a pin over 16 bus cycles
	task toggles(input logic tx, output int n);
		logic p;
		n = 0;
		p = tx ? tck_o : rck_o;
		repeat (16) begin
			@(posedge hclk);
			if ((tx ? tck_o : rck_o) !== p) n++;
			p = tx ? tck_o : rck_o;
		end
	endtask

	task t_reset;
		chk("oe after reset", 32'h0, {rck_oe, tck_oe, dat_oe});
		rdchk("ctrl", audio_pin_pkg::ADDR_CTRL, 32'hff, 32'h0);
		rdchk("port sel", audio_pin_pkg::ADDR_PORT_SEL, 32'h7, 32'h0);
		rdchk("gpio mode", audio_pin_pkg::ADDR_GPIO_MODE, 32'h3f, 32'h0);
		bus(1'b1, 8'h20, 32'h5);
		rdchk("unmapped", 8'h20, 32'hffffffff, 32'h0);
		$display("reset test done");
	endtask

	task t_gpio;
		bus(1'b1, audio_pin_pkg::ADDR_GPIO_MODE, 32'h6);
		bus(1'b1, audio_pin_pkg::ADDR_GPIO_OUT, 32'h7);
		tck_drv <= 1'b1;
		cyc(4);
		chk("port oe", 32'h1, {dat_oe, tck_oe, rck_oe});
		chk("port out", 32'h1, rck_o);
		rdchk("port in", audio_pin_pkg::ADDR_GPIO_IN, 32'h7, 32'h2);
		bus(1'b1, audio_pin_pkg::ADDR_GPIO_MODE, 32'h26);
		cyc(3);
		chk("data port out", 32'h3, {dat_oe, dat_o});
		bus(1'b1, audio_pin_pkg::ADDR_PORT_SEL, 32'h4);
		cyc(6);
		chk("data serial rx oe", 32'h0, dat_oe);
		bus(1'b1, audio_pin_pkg::ADDR_GPIO_MODE, 32'h0);
		$display("port test done");
	endtask

	task t_flag;
		bus(1'b1, audio_pin_pkg::ADDR_PORT_SEL, 32'h1);
		bus(1'b1, audio_pin_pkg::ADDR_CTRL, 32'h15);
		cyc(12);
		chk("flag out", 32'h3, {rck_oe, rck_o});
		bus(1'b1, audio_pin_pkg::ADDR_CTRL, 32'h07);
		cyc(12);
		chk("flag out net", 32'h2, {rck_oe, rck_o});
		rdchk("rx timing", audio_pin_pkg::ADDR_STATUS, 32'h4, 32'h4);
		rck_drv <= 1'b1;
		bus(1'b1, audio_pin_pkg::ADDR_CTRL, 32'h01);
		cyc(12);
		chk("flag in dir", 32'h0, rck_oe);
		rdchk("flag in", audio_pin_pkg::ADDR_STATUS, 32'h5, 32'h5);
		rck_drv <= 1'b0;
		bus(1'b1, audio_pin_pkg::ADDR_CTRL, 32'h03);
		cyc(12);
		rdchk("flag in net", audio_pin_pkg::ADDR_STATUS, 32'h5, 32'h4);
		$display("flag test done");
	endtask

	task t_clock;
		int n;
		bus(1'b1, audio_pin_pkg::ADDR_PORT_SEL, 32'h3);
		bus(1'b1, audio_pin_pkg::ADDR_CTRL, 32'h0c);
		cyc(6);
		chk("clock oe", 32'h3, {tck_oe, rck_oe});
		toggles(1'b0, n);
		chk("rx clock edges", 32'h4, n);
		toggles(1'b1, n);
		chk("tx clock edges", 32'h4, n);
		rdchk("rx timing", audio_pin_pkg::ADDR_STATUS, 32'h4, 32'h0);
		$display("clock test done");
	endtask

	task t_data;
		bus(1'b1, audio_pin_pkg::ADDR_PORT_SEL, 32'h4);
		bus(1'b1, audio_pin_pkg::ADDR_CTRL, 32'h60);
		bus(1'b1, audio_pin_pkg::ADDR_TX_DATA, 32'ha5c3e1);
		cyc(20);
		chk("tx oe", 32'h1, dat_oe);
		chk("tx word", 32'ha5c3e1, got);
		bus(1'b1, audio_pin_pkg::ADDR_CTRL, 32'h80);
		cyc(20);
		rdchk("rx ready", audio_pin_pkg::ADDR_STATUS, 32'h2, 32'h2);
		rdchk("rx word", audio_pin_pkg::ADDR_RX_DATA, 32'hffffff, 32'h3c5a96);
		$display("data test done");
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		hresetn = 1'b0;
		{hsel, hwrite, rck_drv, tck_drv} = 4'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		cyc(20);
		hresetn <= 1'b1;
		cyc(1);
		t_reset;
		t_gpio;
		t_flag;
		t_clock;
		t_data;
		test_done;
	end

	// Watchdog against a hung handshake
	initial begin
		#100000;
		n_fail++;
		test_done;
	end
endmodule
`default_nettype wire
